// ### hw/overtemp_consts.vh
`ifndef OVERTEMP_CONSTS_VH
`define OVERTEMP_CONSTS_VH

// command codes
`define CMD_FAULT_THRESHOLD 8'h4F
`define CMD_FAULT_ACTION 8'h50
`define CMD_WARNING_THRESHOLD 8'h51

// reset values
`define FAULT_THRESHOLD_RESET 16'hEBE8
`define FAULT_ACTION_RESET 8'h80
`define WARNING_THRESHOLD_RESET 16'hEB70

// linear-11 field layout
`define L11_EXP_MSB 15
`define L11_EXP_LSB 11
`define L11_MAN_MSB 10

// action field layout and codes
`define ACT_MODE_MSB 7
`define ACT_MODE_LSB 6
`define ACT_RETRY_MSB 5
`define ACT_RETRY_LSB 3
`define MODE_RETRY 2'h2
`define MODE_RESUME 2'h3
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7

// retry time unit
`define RETRY_UNIT_MS 210
`define CLK_HZ 50000000

`endif

// ### hw/overtemp_fault_protection.v
`timescale 1ns/10ps
`include "overtemp_consts.vh"

module overtemp_fault_protection #(
    parameter PAGES = 2,
    parameter PAGE_W = 1,
    parameter TEMP_W = 16,
    parameter FRAC_W = 4,
    parameter RETRY_CYCLES = (`RETRY_UNIT_MS * (`CLK_HZ / 1000))
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    // command port
    input wire [PAGE_W-1:0] page,
    input wire [7:0] cmd_code,
    input wire cmd_write,
    input wire cmd_read,
    input wire [15:0] cmd_wdata,
    input wire write_protect,
    input wire clear_faults,
    output reg [15:0] cmd_rdata,
    // measurement, signed, FRAC_W fraction bits, one per page
    input wire [PAGES*TEMP_W-1:0] temp_sample,
    input wire [PAGES-1:0] sample_valid,
    // output control
    input wire [PAGES-1:0] output_on_cmd,
    input wire [PAGES-1:0] other_fault,
    output wire [PAGES-1:0] output_enable,
    // status
    output wire [PAGES-1:0] overtemp_fault_flag,
    output wire [PAGES-1:0] overtemp_warning_flag,
    output wire [PAGES-1:0] temperature_status,
    output reg alert_out_n
);

    localparam CNT_W = 32;
    localparam XW = TEMP_W + 24;
    localparam [6:0] FRAC_SH = FRAC_W;
    localparam L11_MAN_W = `L11_MAN_MSB + 1;
    localparam ST_OFF = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_SHUT = 2'h2;
    localparam ST_WAIT = 2'h3;

    // settings and status of every page, flattened for the read mux and the alert
    wire [PAGES*16-1:0] fault_thr_all;
    wire [PAGES*8-1:0] action_all;
    wire [PAGES*16-1:0] warn_thr_all;
    wire [PAGES-1:0] alert_src;

    wire writable = cmd_write && !write_protect;

    // linear-11 to signed fixed point with FRAC_W fraction bits
    function signed [XW-1:0] decode_l11;
        input [15:0] v;
        reg signed [4:0] e;
        reg signed [XW-1:0] m;
        reg signed [6:0] sh;
        begin
            e = v[`L11_EXP_MSB:`L11_EXP_LSB];
            m = {{(XW-L11_MAN_W){v[`L11_MAN_MSB]}}, v[`L11_MAN_MSB:0]};
            sh = {{2{e[4]}}, e} + FRAC_SH;
            if (sh >= 0)
                decode_l11 = m <<< sh;
            else
                decode_l11 = m >>> (-sh);
        end
    endfunction

    // registered read data; unknown codes read zero
    always @(posedge clk) begin
        if (!reset_n) begin
            cmd_rdata <= 16'h0000;
        end else if (clk_en && cmd_read) begin
            case (cmd_code)
                `CMD_FAULT_THRESHOLD: begin
                    cmd_rdata <= fault_thr_all[page*16 +: 16];
                end
                `CMD_FAULT_ACTION: begin
                    cmd_rdata <= {8'h00, action_all[page*8 +: 8]};
                end
                `CMD_WARNING_THRESHOLD: begin
                    cmd_rdata <= warn_thr_all[page*16 +: 16];
                end
                default: begin
                    cmd_rdata <= 16'h0000;
                end
            endcase
        end
    end

    // alert is low while any page has status pending
    always @(posedge clk) begin
        if (!reset_n) begin
            alert_out_n <= 1'b1;
        end else if (clk_en) begin
            alert_out_n <= ~(|alert_src);
        end
    end

    genvar g;
    generate
        for (g = 0; g < PAGES; g = g + 1) begin : pg
            reg [15:0] fault_thr_reg;
            reg [7:0] action_reg;
            reg [15:0] warn_thr_reg;
            reg [1:0] state_reg;
            reg [CNT_W-1:0] retry_cnt_reg;
            reg fault_active_reg;
            reg fault_flag_reg;
            reg warn_flag_reg;
            reg temp_status_reg;
            reg alert_src_reg;
            reg oe_reg;
            wire hit = (page == g);
            wire wr_page = clk_en && writable && hit;
            wire signed [XW-1:0] temp_x =
                {{(XW-TEMP_W){temp_sample[g*TEMP_W+TEMP_W-1]}},
                 temp_sample[g*TEMP_W +: TEMP_W]};
            wire signed [XW-1:0] fault_x = decode_l11(fault_thr_reg);
            wire signed [XW-1:0] warn_x = decode_l11(warn_thr_reg);
            wire over_fault = sample_valid[g] && (temp_x > fault_x);
            wire over_warn = sample_valid[g] && (temp_x > warn_x);
            wire below_warn = sample_valid[g] && (temp_x < warn_x);
            wire [1:0] mode = action_reg[`ACT_MODE_MSB:`ACT_MODE_LSB];
            wire [2:0] retry = action_reg[`ACT_RETRY_MSB:`ACT_RETRY_LSB];
            wire respond = (mode == `MODE_RETRY) || (mode == `MODE_RESUME);
            // a fault is reported once; it must clear through hysteresis first
            wire fault_event = over_fault && !fault_active_reg && respond;
            wire warn_event = over_warn && !fault_event;
            wire status_event = fault_event || over_warn;
            wire restart_due = (retry_cnt_reg >= RETRY_CYCLES - 1);
            wire commanded_off = !output_on_cmd[g] || other_fault[g];

            assign fault_thr_all[g*16 +: 16] = fault_thr_reg;
            assign action_all[g*8 +: 8] = action_reg;
            assign warn_thr_all[g*16 +: 16] = warn_thr_reg;
            assign alert_src[g] = alert_src_reg;
            assign output_enable[g] = oe_reg;
            assign overtemp_fault_flag[g] = fault_flag_reg;
            assign overtemp_warning_flag[g] = warn_flag_reg;
            assign temperature_status[g] = temp_status_reg;

            // fault threshold
            always @(posedge clk) begin
                if (!reset_n) begin
                    fault_thr_reg <= `FAULT_THRESHOLD_RESET;
                end else if (wr_page && (cmd_code == `CMD_FAULT_THRESHOLD)) begin
                    fault_thr_reg <= cmd_wdata;
                end
            end

            // response setting, low byte of the write word
            always @(posedge clk) begin
                if (!reset_n) begin
                    action_reg <= `FAULT_ACTION_RESET;
                end else if (wr_page && (cmd_code == `CMD_FAULT_ACTION)) begin
                    action_reg <= cmd_wdata[7:0];
                end
            end

            // warning threshold
            always @(posedge clk) begin
                if (!reset_n) begin
                    warn_thr_reg <= `WARNING_THRESHOLD_RESET;
                end else if (wr_page && (cmd_code == `CMD_WARNING_THRESHOLD)) begin
                    warn_thr_reg <= cmd_wdata;
                end
            end

            // fault condition with hysteresis down to warning threshold
            always @(posedge clk) begin
                if (!reset_n) begin
                    fault_active_reg <= 1'b0;
                end else if (clk_en) begin
                    if (over_fault) begin
                        fault_active_reg <= 1'b1;
                    end else if (below_warn) begin
                        fault_active_reg <= 1'b0;
                    end
                end
            end

            // sticky fault bit: a new fault wins over a clear in the same cycle
            always @(posedge clk) begin
                if (!reset_n) begin
                    fault_flag_reg <= 1'b0;
                end else if (clk_en) begin
                    if (fault_event) begin
                        fault_flag_reg <= 1'b1;
                    end else if (clear_faults) begin
                        fault_flag_reg <= 1'b0;
                    end
                end
            end

            // sticky warning bit
            always @(posedge clk) begin
                if (!reset_n) begin
                    warn_flag_reg <= 1'b0;
                end else if (clk_en) begin
                    if (warn_event) begin
                        warn_flag_reg <= 1'b1;
                    end else if (clear_faults) begin
                        warn_flag_reg <= 1'b0;
                    end
                end
            end

            // temperature bit of the status word, set by fault or warning
            always @(posedge clk) begin
                if (!reset_n) begin
                    temp_status_reg <= 1'b0;
                end else if (clk_en) begin
                    if (status_event) begin
                        temp_status_reg <= 1'b1;
                    end else if (clear_faults) begin
                        temp_status_reg <= 1'b0;
                    end
                end
            end

            // host notification source of this page
            always @(posedge clk) begin
                if (!reset_n) begin
                    alert_src_reg <= 1'b0;
                end else if (clk_en) begin
                    if (status_event) begin
                        alert_src_reg <= 1'b1;
                    end else if (clear_faults) begin
                        alert_src_reg <= 1'b0;
                    end
                end
            end

            // output control
            always @(posedge clk) begin
                if (!reset_n) begin
                    state_reg <= ST_OFF;
                    retry_cnt_reg <= {CNT_W{1'b0}};
                    oe_reg <= 1'b0;
                end else if (clk_en) begin
                    case (state_reg)
                        ST_OFF: begin
                            oe_reg <= 1'b0;
                            if (!commanded_off && !fault_active_reg) begin
                                state_reg <= ST_RUN;
                            end
                        end
                        ST_RUN: begin
                            oe_reg <= 1'b1;
                            if (commanded_off) begin
                                state_reg <= ST_OFF;
                                oe_reg <= 1'b0;
                            end else if (fault_event) begin
                                oe_reg <= 1'b0;
                                retry_cnt_reg <= {CNT_W{1'b0}};
                                if (mode == `MODE_RESUME) begin
                                    state_reg <= ST_WAIT;
                                end else if (retry == `RETRY_FOREVER) begin
                                    state_reg <= ST_WAIT;
                                end else begin
                                    state_reg <= ST_SHUT;
                                end
                            end
                        end
                        ST_SHUT: begin
                            oe_reg <= 1'b0;
                            if (!output_on_cmd[g] || (clear_faults && !fault_active_reg)) begin
                                state_reg <= ST_OFF;
                            end
                        end
                        ST_WAIT: begin
                            oe_reg <= 1'b0;
                            if (commanded_off) begin
                                state_reg <= ST_OFF;
                            end else if (mode == `MODE_RESUME) begin
                                if (!fault_active_reg) begin
                                    state_reg <= ST_RUN;
                                end
                            end else if (restart_due) begin
                                state_reg <= ST_RUN;
                                oe_reg <= 1'b1;
                            end else begin
                                retry_cnt_reg <= retry_cnt_reg + 1'b1;
                            end
                        end
                        default: begin
                            state_reg <= ST_OFF;
                        end
                    endcase
                end
            end
        end
    endgenerate

endmodule

// ### test/overtemp_asserts.sv
`timescale 1ns/10ps
module overtemp_asserts #(
    parameter PAGES = 2
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    // inputs watched
    input wire clear_faults,
    input wire [PAGES-1:0] sample_valid,
    input wire [PAGES-1:0] output_on_cmd,
    // outputs watched
    input wire [PAGES-1:0] output_enable,
    input wire [PAGES-1:0] overtemp_fault_flag,
    input wire [PAGES-1:0] overtemp_warning_flag,
    input wire [PAGES-1:0] temperature_status,
    input wire alert_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    alert_follow_a: assert property (clk_en && |overtemp_fault_flag |=> !alert_out_n)
        else $error("alert high with fault pending");
    fault_sticky_a: assert property (clk_en && overtemp_fault_flag[0] && !clear_faults
        |=> overtemp_fault_flag[0]) else $error("fault flag dropped");
    warn_sticky_a: assert property (clk_en && overtemp_warning_flag[0] && !clear_faults
        |=> overtemp_warning_flag[0]) else $error("warning flag dropped");
    sample_only_a: assert property (!sample_valid[0] |=> !$rose(overtemp_fault_flag[0]))
        else $error("fault raised without a sample");
    fault_status_a: assert property ($rose(overtemp_fault_flag[0]) |-> temperature_status[0])
        else $error("status bit missing on fault");
    cmd_off_a: assert property (!output_on_cmd[0] [*2] |=> !output_enable[0])
        else $error("output on while commanded off");
    retry_gap_a: assert property ($fell(output_enable[0]) && $rose(overtemp_fault_flag[0])
        |=> !output_enable[0] [*8]) else $error("restart too soon");
    alert_clear_a: assert property (clk_en && clear_faults && sample_valid == 0
        |=> overtemp_fault_flag == 0 ##1 alert_out_n) else $error("clear left alert");
    cover property ($rose(overtemp_fault_flag[0]));
    cover property ($rose(overtemp_warning_flag[0]));
    cover property ($rose(output_enable[0]) && overtemp_fault_flag[0]);
endmodule

// ### test/pmbus_host.sv
`timescale 1ns/10ps
module pmbus_host (
    // clock
    input wire clk,
    // command port
    output reg page,
    output reg [7:0] cmd_code,
    output reg cmd_write,
    output reg cmd_read,
    output reg [15:0] cmd_wdata,
    output reg write_protect,
    output reg clear_faults,
    input wire [15:0] cmd_rdata
);
    initial {page, cmd_code, cmd_write, cmd_read, cmd_wdata, write_protect, clear_faults} = 0;
    // linear-11 words travel whole; data inverted once released
    task wr(input pg, input [7:0] c, input [15:0] dat, input wp);
        begin
            @(posedge clk);
            {page, cmd_code, cmd_wdata, write_protect, cmd_write} <= {pg, c, dat, wp, 1'b1};
            @(posedge clk);
            {cmd_write, cmd_wdata} <= {1'b0, ~dat};
        end
    endtask
    task rd(input pg, input [7:0] c, output [15:0] dat);
        begin
            @(posedge clk);
            {page, cmd_code, cmd_read} <= {pg, c, 1'b1};
            @(posedge clk);
            cmd_read <= 1'b0;
            @(negedge clk);
            dat = cmd_rdata;
        end
    endtask
    task clr;
        begin
            @(posedge clk);
            clear_faults <= 1'b1;
            @(posedge clk);
            clear_faults <= 1'b0;
        end
    endtask
endmodule

// ### test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    reg clk, reset_n;
    reg [31:0] temp_sample;
    reg [1:0] sample_valid, output_on_cmd, other_fault;
    reg clk_en;
    wire page, cmd_write, cmd_read, write_protect, clear_faults, alert_out_n;
    wire [7:0] cmd_code;
    wire [15:0] cmd_wdata, cmd_rdata;
    wire [1:0] output_enable, overtemp_fault_flag, overtemp_warning_flag, temperature_status;
    reg [15:0] d;
    integer failures, num_checks, i;
    overtemp_fault_protection #(.RETRY_CYCLES(20)) u_dut (.clk, .reset_n, .clk_en,
        .page, .cmd_code, .cmd_write, .cmd_read, .cmd_wdata, .write_protect, .clear_faults,
        .cmd_rdata, .temp_sample, .sample_valid, .output_on_cmd, .other_fault,
        .output_enable, .overtemp_fault_flag, .overtemp_warning_flag, .temperature_status,
        .alert_out_n);
    pmbus_host u_host (.clk, .page, .cmd_code, .cmd_write, .cmd_read, .cmd_wdata,
        .write_protect, .clear_faults, .cmd_rdata);
    task check(input [15:0] seen, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task samp(input [15:0] t);
        begin
            @(posedge clk);
            {temp_sample[15:0], sample_valid} <= {t, 2'b01};
            @(posedge clk);
            sample_valid <= 2'b00;
            repeat (10) @(negedge clk);
        end
    endtask
    task wait_oe(input e, input integer n);
        begin
            i = 0;
            while (output_enable[0] !== e && i < n) begin
                @(negedge clk);
                i = i + 1;
            end
        end
    endtask
    task t_regs;
        begin
            u_host.rd(0, 8'h4F, d); check(d, 16'hEBE8);
            u_host.rd(0, 8'h50, d); check(d, 16'h0080);
            u_host.rd(0, 8'h51, d); check(d, 16'hEB70);
            u_host.rd(0, 8'h52, d); check(d, 16'h0000);
            u_host.wr(0, 8'h4F, 16'h0000, 1);
            u_host.wr(1, 8'h4F, 16'hF8C8, 0);
            u_host.rd(0, 8'h4F, d); check(d, 16'hEBE8);
            u_host.rd(1, 8'h4F, d); check(d, 16'hF8C8);
            @(posedge clk) clk_en <= 1'b0;
            u_host.wr(1, 8'h4F, 16'h0000, 0);
            @(posedge clk) clk_en <= 1'b1;
            u_host.rd(1, 8'h4F, d); check(d, 16'hF8C8);
            $display("test regs done");
        end
    endtask
    task t_warn;
        begin
            samp(16'h0730);
            check(overtemp_warning_flag[0], 1);
            check(temperature_status[0], 1);
            check({overtemp_fault_flag[0], output_enable[0], alert_out_n}, 3'b010);
            check({overtemp_warning_flag[1], output_enable[1]}, 2'b01);
            @(posedge clk) other_fault <= 2'b01;
            repeat (3) @(negedge clk);
            check(output_enable[0], 0);
            @(posedge clk) other_fault <= 2'b00;
            wait_oe(1, 10);
            check(output_enable[0], 1);
            $display("test warning done");
        end
    endtask
    task t_noretry;
        begin
            u_host.wr(0, 8'h4F, 16'hF8C8, 0);
            u_host.clr;
            samp(16'h0690);
            check({overtemp_fault_flag[0], output_enable[0]}, 2'b10);
            samp(16'h0640);
            check(output_enable[0], 0);
            u_host.clr;
            wait_oe(1, 10);
            check(output_enable[0], 1);
            u_host.wr(0, 8'h4F, 16'hEBE8, 0);
            $display("test no retry done");
        end
    endtask
    task t_resume;
        begin
            u_host.wr(0, 8'h50, 16'h00C0, 0);
            u_host.clr;
            samp(16'h0820);
            check(output_enable[0], 0);
            samp(16'h0730);
            check(output_enable[0], 0);
            samp(16'h0640);
            wait_oe(1, 10);
            check(output_enable[0], 1);
            $display("test resume done");
        end
    endtask
    task t_retry;
        begin
            u_host.wr(0, 8'h50, 16'h00B8, 0);
            u_host.clr;
            samp(16'h0820);
            check(output_enable[0], 0);
            wait_oe(1, 20);
            check(output_enable[0], 1);
            @(posedge clk) output_on_cmd <= 2'b10;
            repeat (3) @(negedge clk);
            check(output_enable[0], 0);
            @(posedge clk) output_on_cmd <= 2'b11;
            $display("test retry done");
        end
    endtask
    task results;
        begin
            $display("checks %0d failures %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    initial begin
        {reset_n, temp_sample, sample_valid, failures, num_checks} = 0;
        output_on_cmd = 2'b11;
        other_fault = 2'b00;
        clk_en = 1'b1;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        t_regs;
        t_warn;
        t_noretry;
        t_resume;
        t_retry;
        results;
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures = failures + 1;
        results;
    end
endmodule
bind overtemp_fault_protection overtemp_asserts #(.PAGES(PAGES)) u_chk (.clk, .reset_n,
    .clk_en, .clear_faults, .sample_valid, .output_on_cmd, .output_enable,
    .overtemp_fault_flag, .overtemp_warning_flag, .temperature_status, .alert_out_n);
